// File: dv/osc_model.sv
// Oscillator model: selected-source and watchdog oscillator tick pulses
module osc_model #(
    parameter int SRC_PERIOD  = 3,
    parameter int WDOG_PERIOD = 7
) (
    input  wire logic clk_in,
    output logic      src_tick_out  = 1'b0,
    output logic      wdog_tick_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int src_cnt  = 0;
    int wdog_cnt = 0;
    // Watchdog oscillator runs free whatever source the chip uses
    always_ff @(posedge clk_in) begin
        wdog_cnt      <= (wdog_cnt == WDOG_PERIOD - 1) ? 0 : wdog_cnt + 1;
        wdog_tick_out <= (wdog_cnt == WDOG_PERIOD - 1);
    end
    // Periods share no factor so the two tick trains drift apart
    always_ff @(posedge clk_in) begin
        src_cnt      <= (src_cnt == SRC_PERIOD - 1) ? 0 : src_cnt + 1;
        src_tick_out <= (src_cnt == SRC_PERIOD - 1);
    end
endmodule : osc_model

// File: dv/tb_top.sv
// Self-checking bench for the clock source and start-up control block
module tb_top
    import clk_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_in = 1'b0;
    logic              sys_rst_in = 1'b1;
    logic              cyc = 1'b0, stb = 1'b0, we = 1'b0, div8 = 1'b0, wdog_prev = 1'b0;
    logic              ext_int = 1'b0, ser_start = 1'b0, irq_wake = 1'b0;
    logic [3:0]        adr = 4'h0, src_sel = 4'h2;
    logic [1:0]        st_sel = 2'h2;
    logic [7:0]        trim_f = 8'ha5;
    logic [31:0]       dat_w = 32'h0, rd;
    wire  logic [31:0] dat_r;
    wire  logic [7:0]  trim_out;
    wire  logic [4:0]  en;
    wire  logic        ack, sys_tick, wdog_tick, src_tick, wdog_osc;
    int                failures = 0, total_checks = 0, i, cnt;
    logic [3:0]        src_t [5] = '{4'h8, 4'h0, 4'h3, 4'h6, 4'h2};
    logic [1:0]        st_t  [5] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h2};
    logic [2:0]        mode_t[5] = '{MODE_IDLE, MODE_ADC, MODE_PDOWN, MODE_PSAVE, MODE_STBY};
    logic [4:0]        gate_t[5] = '{5'h1a, 5'h18, 5'h00, 5'h08, 5'h00};

    always #10 clk_in = ~clk_in;

    // Long watchdog count shortened to keep the run brief
    clock_source_and_startup_control #(.WDOG_LONG_CYCLES(64), .WAKE_XTAL_CYCLES(20)) uut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(dat_w),
        .wb_dat_out(dat_r), .wb_ack_out(ack), .clock_source_select_in(src_sel),
        .startup_time_select_in(st_sel), .divide_by_eight_option_in(div8),
        .factory_trim_in(trim_f), .src_tick_in(src_tick), .wdog_osc_tick_in(wdog_osc),
        .ext_int_async_in(ext_int), .serial_start_in(ser_start), .irq_wake_in(irq_wake),
        .core_clock_en_out(en[0]), .peripheral_clock_en_out(en[1]),
        .program_memory_clock_en_out(en[2]), .async_timer_clock_en_out(en[3]),
        .converter_clock_en_out(en[4]), .sys_tick_out(sys_tick), .wdog_tick_out(wdog_tick),
        .oscillator_trim_out(trim_out));

    osc_model osc (.clk_in(clk_in), .src_tick_out(src_tick), .wdog_tick_out(wdog_osc));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_span(input int v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask : check_span

    task automatic wrap_up;
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        @(posedge clk_in);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_in);
        end
        check({31'h0, ack}, 32'h1);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic pulse(input logic [1:0] which);
        @(posedge clk_in);
        irq_wake  <= (which == 2'h0);
        ext_int   <= (which == 2'h1);
        ser_start <= (which == 2'h2);
        @(posedge clk_in);
        {irq_wake, ext_int, ser_start} <= 3'h0;
    endtask : pulse

    // Ticks of one oscillator seen until the core clock is enabled again
    task automatic count_run(input logic use_wd, output int n);
        int k;
        n = 0;
        for (k = 0; k < 40000 && en[G_CORE] !== 1'b1; k++) begin
            @(posedge clk_in);
            n += use_wd ? wdog_osc : src_tick;
        end
    endtask : count_run

    function automatic logic [1:0] kind_of(input logic [3:0] s);
        if (s[3]) return 2'h0;
        if (s[3:1] == 3'h3) return 2'h1;
        if (s == 4'h0) return 2'h3;
        return 2'h2;
    endfunction : kind_of

    always @(posedge clk_in) begin
        wdog_prev <= wdog_osc;
    end
    always @(negedge clk_in) begin
        if (!sys_rst_in && en[G_CORE] === 1'b1) check({31'h0, wdog_tick}, {31'h0, wdog_prev});
    end

    initial begin
        for (i = 0; i < 5; i++) begin
            @(posedge clk_in);
            sys_rst_in <= 1'b1;
            src_sel    <= src_t[i];
            st_sel     <= st_t[i];
            div8       <= i[0];
            repeat (12) @(posedge clk_in);
            check({24'h0, trim_out}, {24'h0, trim_f});
            sys_rst_in <= 1'b0;
            bus(1'b0, ADR_CFG, 32'h0);
            check(rd, {22'h0, kind_of(src_t[i]), (src_t[i] inside {4'h1, 4'h3, 4'h4, 4'h5}),
                       i[0], st_t[i], src_t[i]});
            if (st_t[i] != 2'h0) begin
                bus(1'b0, ADR_STAT, 32'h0);
                check(rd, 32'h0);
            end
            count_run(1'b1, cnt);
            cnt -= (st_t[i] == 2'h0) ? 0 : (st_t[i] == 2'h1) ? 4096 : 64;
            check_span(cnt, -2, 10);
            cnt = 0;
            repeat (240) begin
                @(posedge clk_in);
                cnt += sys_tick;
            end
            check_span(cnt, i[0] ? 79 : 9, i[0] ? 81 : 11);
        end
        bus(1'b0, ADR_CFG, 32'h0);
        check(rd, 32'h222);
        bus(1'b1, ADR_TRIM, 32'h3c);
        bus(1'b1, ADR_CFG, 32'hff);
        bus(1'b0, ADR_TRIM, 32'h0);
        check(rd, 32'h3c);
        check({24'h0, trim_out}, 32'h3c);
        bus(1'b0, ADR_CFG, 32'h0);
        check(rd, 32'h222);
        bus(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0);
        for (i = 0; i < 5; i++) begin
            bus(1'b1, ADR_SLEEP, {28'h0, 1'b1, mode_t[i]});
            repeat (20) @(posedge clk_in);
            check({27'h0, en}, {27'h0, gate_t[i]});
            bus(1'b0, ADR_STAT, 32'h0);
            check(rd, {24'h3, 3'h0, gate_t[i]});
            pulse(2'h0);
            repeat (30) @(posedge clk_in);
            check({31'h0, en[G_CORE]}, {31'h0, i == 0});
            if (i != 0) begin
                pulse(i[0] ? 2'h1 : 2'h2);
                count_run(1'b0, cnt);
                check_span(cnt, (i == 2 || i == 3) ? 6 : 0, (i == 2 || i == 3) ? 9 : 3);
            end
            repeat (10) @(posedge clk_in);
            check({27'h0, en}, 32'h1f);
        end
        wrap_up();
    end

    // Whole run needs about 0.7 ms; allow roughly three times that
    initial begin
        #2000000;
        failures++;
        wrap_up();
    end
endmodule : tb_top

// File: include/clk_ctrl_pkg.sv
// Constants, types and helpers shared by the clock control block
package clk_ctrl_pkg;
    // Register byte offsets
    localparam logic [3:0] ADR_TRIM  = 4'h0;
    localparam logic [3:0] ADR_CFG   = 4'h4;
    localparam logic [3:0] ADR_STAT  = 4'h8;
    localparam logic [3:0] ADR_SLEEP = 4'hc;
    // Field positions
    localparam int CFG_SRC_LSB    = 0;
    localparam int CFG_ST_LSB     = 4;
    localparam int CFG_DIV8_BIT   = 6;
    localparam int CFG_RSV_BIT    = 7;
    localparam int CFG_KIND_LSB   = 8;
    localparam int STAT_STATE_LSB = 8;
    localparam int SLP_MODE_LSB   = 0;
    localparam int SLP_GO_BIT     = 3;
    // Gate vector bit positions
    localparam int G_CORE  = 0;
    localparam int G_IO    = 1;
    localparam int G_FLASH = 2;
    localparam int G_ASY   = 3;
    localparam int G_ADC   = 4;
    // Shipped configuration, also the safe fallback
    localparam logic [3:0] DEF_SRC  = 4'h2;
    localparam logic [1:0] DEF_ST   = 2'h2;
    localparam logic       DEF_DIV8 = 1'b0;
    localparam logic [3:0] SRC_CODE_EXT  = 4'h0;
    localparam logic [1:0] ST_CODE_NONE  = 2'h0;
    localparam logic [1:0] ST_CODE_SHORT = 2'h1;
    localparam logic [1:0] ST_CODE_RSV   = 2'h3;
    // Timing counts, in source or watchdog oscillator cycles
    localparam logic [16:0] FIXED_RESET_CK    = 17'h0000e;
    localparam logic [16:0] WAKE_RC_CK        = 17'h00006;
    localparam logic [16:0] WDOG_SHORT_CYCLES = 17'h01000;
    // Sleep mode codes
    localparam logic [2:0] MODE_IDLE  = 3'h0;
    localparam logic [2:0] MODE_ADC   = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY  = 3'h6;

    typedef enum logic [1:0] {KIND_XTAL, KIND_LFXTAL, KIND_RCOSC, KIND_EXTCLK} src_kind_t;
    typedef enum logic [2:0] {S_WDOG, S_CK, S_RUN, S_SLEEP, S_WAKE} state_t;

    function automatic logic src_reserved(input logic [3:0] code);
        return (code == 4'h3) || (code == 4'h1) || (code == 4'h5) || (code == 4'h4);
    endfunction : src_reserved

    // Reserved codes land on the internal oscillator
    function automatic src_kind_t src_kind(input logic [3:0] code);
        if (code[3]) begin
            return KIND_XTAL;
        end
        if (code[3:1] == 3'h3) begin
            return KIND_LFXTAL;
        end
        if (code == SRC_CODE_EXT) begin
            return KIND_EXTCLK;
        end
        return KIND_RCOSC;
    endfunction : src_kind

    // Gate vector {adc, asy, flash, io, core}
    function automatic logic [4:0] gates(input state_t st, input logic [2:0] mode);
        logic [4:0] g;
        g = 5'h00;
        unique case (st)
            S_RUN: g = 5'h1f;
            S_SLEEP: begin
                if (mode == MODE_IDLE) begin
                    g = 5'h1a;
                end else if (mode == MODE_ADC) begin
                    g = 5'h18;
                end else if (mode == MODE_PSAVE) begin
                    g = 5'h08;
                end
            end
            S_WAKE: g = (mode == MODE_PSAVE) ? 5'h08 : 5'h00;
            S_WDOG, S_CK: g = 5'h00;
        endcase
        return g;
    endfunction : gates
endpackage : clk_ctrl_pkg

// File: src/clock_prescaler.sv
// Optional divide-by-eight of the source clock, as a one-cycle tick
module clock_prescaler
    import clk_ctrl_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic tick_in,
    input  wire logic div8_in,
    output logic      tick_out
);
    logic [2:0] cnt_reg;
    logic       tick_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_reg <= 3'h0;
        end else if (tick_in) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_in && (!div8_in || cnt_reg == 3'h7);
        end
    end

    assign tick_out = tick_reg;

    a_div_eighth: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (div8_in && $past(div8_in) && tick_reg) |-> $past(cnt_reg) == 3'h7)
        else $error("divided tick not on eighth source tick");
endmodule : clock_prescaler

// File: src/clock_source_and_startup_control.sv
// Clock source selection, start-up timing, prescale, trim and clock gating
// Summary of operation
// - Four-bit select field picks clock source
// - Stored one unprogrammed, zero programmed
// - Codes 0011, 0001, 0101, 0100 reserved
// - Deep-sleep wake timed on selected source
// - Reset delay counted on watchdog oscillator
// - Default: internal RC, longest start, divided
// - Programmed option divides clock by eight
// - Reset loads factory byte into trim
// - Software may overwrite trim; trim applied
// - Watchdog always runs on its own oscillator
// - Internal RC deep wake takes 6 cycles
// - Start field picks extra reset delay
// - Sleep mode gates unused clocks off
// - Async inputs wake with peripheral clock halted
// - Async timer domain runs during idle, ADC noise and power-save sleep
// - Converter has own domain during noise mode
//
// Local design decisions: the placing of the registers and the Wishbone register port.
module clock_source_and_startup_control
    import clk_ctrl_pkg::*;
#(
    parameter int WDOG_LONG_CYCLES = 65536,
    parameter int WAKE_XTAL_CYCLES = 16384
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    // Non-volatile configuration and factory trim
    input  wire logic [3:0]  clock_source_select_in,
    input  wire logic [1:0]  startup_time_select_in,
    input  wire logic        divide_by_eight_option_in,
    input  wire logic [7:0]  factory_trim_in,
    // Oscillator ticks
    input  wire logic        src_tick_in,
    input  wire logic        wdog_osc_tick_in,
    // Wake sources
    input  wire logic        ext_int_async_in,
    input  wire logic        serial_start_in,
    input  wire logic        irq_wake_in,
    // Clock domain enables and derived outputs
    output logic             core_clock_en_out,
    output logic             peripheral_clock_en_out,
    output logic             program_memory_clock_en_out,
    output logic             async_timer_clock_en_out,
    output logic             converter_clock_en_out,
    output logic             sys_tick_out,
    output logic             wdog_tick_out,
    output logic [7:0]       oscillator_trim_out
);
    // Captured configuration
    logic [3:0]  src_sel_reg;
    logic [1:0]  st_sel_reg;
    logic        div8_reg;
    logic [7:0]  trim_reg;
    logic [2:0]  mode_reg;
    logic        first_reg;
    state_t      state;
    state_t      state_next;
    logic [4:0]  gate_reg;
    logic        wdog_tick_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    // Derived
    src_kind_t   kind_w;
    logic        rsv_w;
    logic [1:0]  st_eff;
    logic [16:0] wdog_target;
    logic [16:0] wake_target;
    logic [16:0] src_target;
    logic        wdog_start;
    logic        src_start;
    logic        wdog_busy;
    logic        wdog_done;
    logic        src_busy;
    logic        src_done;
    logic        deep_mode;
    logic        wake_any;
    logic        wb_hit;
    logic        wb_wr;
    logic        sleep_go;
    logic [31:0] rd_data;
    // Assertion helpers
    logic [16:0] ck_ticks_reg;
    logic [16:0] wdog_ticks_reg;

    // Configuration is latched while reset is held
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            src_sel_reg <= clock_source_select_in;
            st_sel_reg  <= startup_time_select_in;
            div8_reg    <= divide_by_eight_option_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // Trim: factory byte under reset, software may refine it later
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            trim_reg <= factory_trim_in;
        end else if (wb_wr && wb_adr_in == ADR_TRIM && wb_sel_in[0]) begin
            trim_reg <= wb_dat_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_reg <= MODE_IDLE;
        end else if (wb_wr && wb_adr_in == ADR_SLEEP && wb_sel_in[0]) begin
            mode_reg <= wb_dat_in[SLP_MODE_LSB +: 3];
        end
    end

    assign kind_w = src_kind(src_sel_reg);
    assign rsv_w  = src_reserved(src_sel_reg);
    // Reserved start code takes the longest delay
    assign st_eff = (st_sel_reg == ST_CODE_RSV) ? DEF_ST : st_sel_reg;

    always_comb begin
        if (st_eff == ST_CODE_NONE) begin
            wdog_target = 17'h00000;
        end else if (st_eff == ST_CODE_SHORT) begin
            wdog_target = WDOG_SHORT_CYCLES;
        end else begin
            wdog_target = 17'(WDOG_LONG_CYCLES);
        end
    end

    // Crystals need far longer to settle than the RC or a driven clock
    assign wake_target = (kind_w == KIND_RCOSC || kind_w == KIND_EXTCLK)
                       ? WAKE_RC_CK : 17'(WAKE_XTAL_CYCLES);
    assign src_target  = (state_next == S_CK) ? FIXED_RESET_CK : wake_target;

    assign wdog_start = first_reg;
    assign src_start  = (state_next != state)
                     && (state_next == S_CK || state_next == S_WAKE);

    // Reset delay runs on the watchdog oscillator, whatever the source
    startup_counter u_wdog_cnt (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .start_in   (wdog_start),
        .target_in  (wdog_target),
        .tick_in    (wdog_osc_tick_in),
        .busy_out   (wdog_busy),
        .done_out   (wdog_done)
    );

    // Fixed reset cycles and deep-sleep wake run on the selected source
    startup_counter u_src_cnt (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .start_in   (src_start),
        .target_in  (src_target),
        .tick_in    (src_tick_in),
        .busy_out   (src_busy),
        .done_out   (src_done)
    );

    assign deep_mode = (mode_reg == MODE_PDOWN) || (mode_reg == MODE_PSAVE);
    // Async sources wake even with the peripheral clock stopped
    assign wake_any  = ext_int_async_in || serial_start_in
                    || (irq_wake_in && gate_reg[G_IO]);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= S_WDOG;
        end else begin
            state <= state_next;
        end
    end

    always_comb begin
        state_next = state;
        unique case (state)
            S_WDOG: begin
                if (wdog_done) begin
                    state_next = S_CK;
                end
            end
            S_CK: begin
                if (src_done) begin
                    state_next = S_RUN;
                end
            end
            S_RUN: begin
                if (sleep_go) begin
                    state_next = S_SLEEP;
                end
            end
            S_SLEEP: begin
                if (wake_any) begin
                    state_next = deep_mode ? S_WAKE : S_RUN;
                end
            end
            S_WAKE: begin
                if (src_done) begin
                    state_next = S_RUN;
                end
            end
        endcase
    end

    // Enables move only on a source tick so no domain sees a runt pulse
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            gate_reg <= 5'h00;
        end else if (src_tick_in) begin
            gate_reg <= gates(state, mode_reg);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wdog_tick_reg <= 1'b0;
        end else begin
            wdog_tick_reg <= wdog_osc_tick_in;
        end
    end

    // Stored zero means programmed, so the divider runs on a zero
    clock_prescaler u_presc (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .tick_in    (src_tick_in),
        .div8_in    (div8_reg == DEF_DIV8),
        .tick_out   (sys_tick_out)
    );

    // Wishbone: one wait state, ack drops the cycle after it rises
    assign wb_hit = wb_cyc_in && wb_stb_in && !ack_reg;
    assign wb_wr  = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg;
    assign sleep_go = wb_wr && wb_adr_in == ADR_SLEEP && wb_sel_in[0]
                   && wb_dat_in[SLP_GO_BIT] && state == S_RUN;

    always_comb begin
        rd_data = 32'h00000000;
        unique case (wb_adr_in)
            ADR_TRIM: rd_data[7:0] = trim_reg;
            ADR_CFG: begin
                rd_data[CFG_SRC_LSB +: 4]  = src_sel_reg;
                rd_data[CFG_ST_LSB +: 2]   = st_sel_reg;
                rd_data[CFG_DIV8_BIT]      = div8_reg;
                rd_data[CFG_RSV_BIT]       = rsv_w;
                rd_data[CFG_KIND_LSB +: 2] = kind_w;
            end
            ADR_STAT: begin
                rd_data[4:0]                 = gate_reg;
                rd_data[STAT_STATE_LSB +: 3] = state;
            end
            ADR_SLEEP: rd_data[SLP_MODE_LSB +: 3] = mode_reg;
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_hit;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dat_reg <= 32'h00000000;
        end else if (wb_hit) begin
            dat_reg <= wb_we_in ? 32'h00000000 : rd_data;
        end
    end

    assign wb_ack_out                  = ack_reg;
    assign wb_dat_out                  = dat_reg;
    assign core_clock_en_out           = gate_reg[G_CORE];
    assign peripheral_clock_en_out     = gate_reg[G_IO];
    assign program_memory_clock_en_out = gate_reg[G_FLASH];
    assign async_timer_clock_en_out    = gate_reg[G_ASY];
    assign converter_clock_en_out      = gate_reg[G_ADC];
    assign wdog_tick_out               = wdog_tick_reg;
    assign oscillator_trim_out         = trim_reg;

    // Tick counters used only by the checks below
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || state_next != state) begin
            ck_ticks_reg <= 17'h00000;
        end else if (src_tick_in && src_busy && !src_done) begin
            ck_ticks_reg <= ck_ticks_reg + 17'h00001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || state != S_WDOG) begin
            wdog_ticks_reg <= 17'h00000;
        end else if (wdog_osc_tick_in && wdog_busy && !wdog_done) begin
            wdog_ticks_reg <= wdog_ticks_reg + 17'h00001;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_trim_reset_load: assert property (
        $past(sys_rst_in) |-> oscillator_trim_out == $past(factory_trim_in))
        else $error("trim not loaded from factory byte");
    a_trim_sw_write: assert property (
        (wb_wr && wb_adr_in == ADR_TRIM && wb_sel_in[0])
        |=> oscillator_trim_out == $past(wb_dat_in[7:0]))
        else $error("software trim write not applied");
    a_wake_rc_six: assert property (
        (state == S_WAKE && src_done && kind_w == KIND_RCOSC) |-> ck_ticks_reg == 17'h00006)
        else $error("internal oscillator wake not six cycles");
    a_reset_fixed_ck: assert property (
        (state == S_CK && src_done) |-> ck_ticks_reg == 17'h0000e)
        else $error("fixed reset delay not fourteen cycles");
    a_short_timeout: assert property (
        (state == S_WDOG && wdog_done && st_eff == ST_CODE_SHORT)
        |-> wdog_ticks_reg == 17'h01000)
        else $error("short watchdog time-out miscounted");
    a_no_timeout: assert property (
        (state == S_WDOG && wdog_done && st_sel_reg == ST_CODE_NONE)
        |-> wdog_ticks_reg == 17'h00000)
        else $error("zero watchdog delay counted ticks");
    a_reserved_fallback: assert property (
        rsv_w |-> kind_w == KIND_RCOSC)
        else $error("reserved select did not fall back");
    a_gate_boundary: assert property (
        $changed(gate_reg) |-> $past(src_tick_in))
        else $error("clock enable changed off a source tick");
    a_core_off_sleep: assert property (
        ($past(state) == S_SLEEP && $past(src_tick_in)) |-> !core_clock_en_out)
        else $error("core clock running in sleep");
    a_adc_noise_mode: assert property (
        ($past(state) == S_SLEEP && $past(mode_reg) == MODE_ADC && $past(src_tick_in))
        |-> converter_clock_en_out && !peripheral_clock_en_out)
        else $error("converter domain wrong in noise mode");
    a_async_wake: assert property (
        (state == S_SLEEP && (ext_int_async_in || serial_start_in)) |=> state != S_SLEEP)
        else $error("async wake source ignored");
    a_wdog_follows: assert property (
        wdog_tick_out == ($past(sys_rst_in) ? 1'b0 : $past(wdog_osc_tick_in)))
        else $error("watchdog tick not passed through");
    a_wb_ack_pulse: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");

    c_reset_to_run: cover property (state == S_CK ##1 state == S_RUN);
    c_deep_wake: cover property (state == S_WAKE && src_done);
    c_shallow_wake: cover property (state == S_SLEEP ##1 state == S_RUN);
    c_trim_write: cover property (wb_wr && wb_adr_in == ADR_TRIM);
endmodule : clock_source_and_startup_control

// File: src/startup_counter.sv
// Down counter that times a start-up interval in ticks of a reference
module startup_counter
    import clk_ctrl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        start_in,
    input  wire logic [16:0] target_in,
    input  wire logic        tick_in,
    output logic             busy_out,
    output logic             done_out
);
    logic [16:0] cnt_reg;
    logic        busy_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_reg  <= 17'h00000;
            busy_reg <= 1'b0;
        end else if (start_in) begin
            cnt_reg  <= target_in;
            busy_reg <= 1'b1;
        end else if (done_out) begin
            busy_reg <= 1'b0;
        end else if (busy_reg && tick_in) begin
            cnt_reg <= cnt_reg - 17'h00001;
        end
    end

    assign busy_out = busy_reg;
    assign done_out = busy_reg && (cnt_reg == 17'h00000);
endmodule : startup_counter
